// ===== core/led_ctrl.sv
// LED matrix driver control: interrupt, sync, shutdown and de-ghost logic
// Functional notes
// - Mask register picks which of open, short and three breath-done events raise interrupt.
// - Enabled open event pulls interrupt low and sets open flag together.
// - Completed read of the flags register releases the interrupt pin high.
// - With auto-clear set, interrupt releases itself after staying low about 8 ms.
// - All flags return to zero when a flags read or auto-clear sends the interrupt pin high, but not when a mask write does.
// - Sync select 01: master, drive own sync clock on the sync pin.
// - Sync select 10: slave, scan timing locks to the incoming sync clock.
// - Sync select 00 or 11: sync pin undriven, synchronisation off.
// - Sync select resets to 00, so sync pin starts undriven.
// - Soft shutdown bit at 0 switches all current sources off, blanking the matrix.
// - Registers stay readable and writable during soft shutdown.
// - Register contents are kept unchanged in either shutdown mode.
// - Shutdown pin low puts the device in hardware shutdown, analog off.
// - Shutdown pin high ends hardware shutdown and resumes normal operation.
// - Function registers remain accessible during hardware shutdown.
// - De-ghost pull resistors are enabled only while their output is off.
// - Switch pull-up value from register 0Fh, source pull-down from register 10h.
module led_ctrl
  import led_ctrl_pkg::*;
#(
  parameter int AUTO_CLEAR_COUNT = int'(AUTO_CLEAR_CYCLES),
  parameter int SCAN_COUNT       = int'(SCAN_CYCLES),
  parameter int CS_LINES         = 4,
  parameter int SW_LINES         = 3
)
(
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  input  wire logic                hw_shutdown_n,
  input  wire logic                sync_i,
  output logic                     sync_o,
  output logic                     sync_oe,
  input  wire logic                open_event,
  input  wire logic                short_event,
  input  wire logic [2:0]          breath_done,
  input  wire logic [CS_LINES-1:0] cs_on,
  input  wire logic [SW_LINES-1:0] sw_on,
  output logic                     irq_out_n,
  output logic                     scan_tick,
  output logic                     source_enable,
  output logic                     analog_enable,
  output logic                     breath_enable,
  output logic                     detect_start,
  output logic [CS_LINES-1:0]      cs_pulldown_en,
  output logic [SW_LINES-1:0]      sw_pullup_en,
  output logic [7:0]               sw_pullup_sel,
  output logic [7:0]               cs_pulldown_sel
);
  localparam int ACW = $clog2(AUTO_CLEAR_COUNT + 1);
  localparam int SCW = $clog2(SCAN_COUNT + 1);

  if (AUTO_CLEAR_COUNT < 1)
  begin : g_chk_ac
    $error("AUTO_CLEAR_COUNT must be at least 1");
  end
  if (SCAN_COUNT < 2)
  begin : g_chk_scan
    $error("SCAN_COUNT must be at least 2");
  end

  host_reg_if bus ();

  serial_slave u_link (
    .ref_clk (ref_clk),
    .srst    (srst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .bus     (bus.link)
  );

  logic [7:0]          chip_configuration;
  logic [7:0]          switch_pullup_select;
  logic [7:0]          source_pulldown_select;
  logic [7:0]          interrupt_enable_mask;
  logic [7:0]          interrupt_flags;
  logic [7:0]          next_flags;
  logic [ACW-1:0]      ac_cnt;
  logic                ac_expire;
  logic [2:0]          sd_s;
  logic                sd_f;
  logic [2:0]          sy_s;
  logic                sy_f;
  logic                sy_q;
  logic [SCW-1:0]      scan_cnt;
  logic                trig_q;
  logic [EV_COUNT-1:0] events;
  sync_sel_t           sync_sel;

  function automatic logic hit(input logic [7:0] ofs);
    hit = bus.wr_stb && (bus.addr == ofs);
  endfunction

  assign sync_sel = sync_sel_t'(chip_configuration[CFG_SYNC_LO +: 2]);
  assign events = {breath_done, short_event, open_event};

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    case (bus.addr)
      OFS_CHIP_CONFIGURATION:     bus.rdata = chip_configuration;
      OFS_SWITCH_PULLUP_SELECT:   bus.rdata = switch_pullup_select;
      OFS_SOURCE_PULLDOWN_SELECT: bus.rdata = source_pulldown_select;
      OFS_INTERRUPT_ENABLE_MASK:  bus.rdata = interrupt_enable_mask;
      OFS_INTERRUPT_FLAGS:        bus.rdata = interrupt_flags;
      default:                    bus.rdata = 8'h00;
    endcase
  end

  // Writes are never gated by either shutdown, and shutdown never touches contents
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      chip_configuration <= RST_CHIP_CONFIGURATION;
      switch_pullup_select <= RST_SWITCH_PULLUP_SELECT;
      source_pulldown_select <= RST_SOURCE_PULLDOWN_SELECT;
      interrupt_enable_mask <= RST_INTERRUPT_ENABLE_MASK;
    end
    else
    begin
      if (hit(OFS_CHIP_CONFIGURATION))
        chip_configuration <= bus.wdata;
      if (hit(OFS_SWITCH_PULLUP_SELECT))
        switch_pullup_select <= bus.wdata;
      if (hit(OFS_SOURCE_PULLDOWN_SELECT))
        source_pulldown_select <= bus.wdata;
      if (hit(OFS_INTERRUPT_ENABLE_MASK))
        interrupt_enable_mask <= bus.wdata;
    end
  end

  // Clearing on read or auto release; a same-cycle event survives the clear
  always_comb
  begin
    next_flags = interrupt_flags;
    if ((bus.rd_stb && bus.addr == OFS_INTERRUPT_FLAGS) || ac_expire)
      next_flags = 8'h00;
    next_flags[EV_COUNT-1:0] = next_flags[EV_COUNT-1:0]
                             | (events & interrupt_enable_mask[EV_COUNT-1:0]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      interrupt_flags <= RST_INTERRUPT_FLAGS;
      irq_out_n <= 1'b1;
    end
    else
    begin
      interrupt_flags <= next_flags;
      irq_out_n <= ~|(next_flags[EV_COUNT-1:0] & interrupt_enable_mask[EV_COUNT-1:0]);
    end
  end

  // Auto-release timer runs only while the pin is low
  assign ac_expire = interrupt_enable_mask[MASK_IRQ_AUTO_CLEAR] && !irq_out_n
                     && (ac_cnt == ACW'(AUTO_CLEAR_COUNT - 1));

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ac_cnt <= '0;
    else if (irq_out_n || !interrupt_enable_mask[MASK_IRQ_AUTO_CLEAR] || ac_expire)
      ac_cnt <= '0;
    else
      ac_cnt <= ac_cnt + 1'b1;
  end

  // Shutdown pin through three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    sd_s <= {sd_s[1:0], hw_shutdown_n};
    if (srst)
      sd_f <= 1'b0;
    else if (sd_s[2] == sd_s[1])
      sd_f <= sd_s[2];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      analog_enable <= 1'b0;
      source_enable <= 1'b0;
      breath_enable <= 1'b0;
    end
    else
    begin
      analog_enable <= sd_f;
      source_enable <= sd_f && chip_configuration[CFG_SOFT_SHUTDOWN_N];
      breath_enable <= sd_f && chip_configuration[CFG_BREATH_EN];
    end
  end

  // Detection runs once per rising edge of the trigger bit
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      trig_q <= 1'b0;
      detect_start <= 1'b0;
    end
    else
    begin
      trig_q <= chip_configuration[CFG_DETECT_TRIGGER];
      detect_start <= chip_configuration[CFG_DETECT_TRIGGER] && !trig_q;
    end
  end

  // Sync input through three stages, then edge detection on the settled level
  always_ff @(posedge ref_clk)
  begin
    sy_s <= {sy_s[1:0], sync_i};
    if (srst)
    begin
      sy_f <= 1'b0;
      sy_q <= 1'b0;
    end
    else
    begin
      if (sy_s[2] == sy_s[1])
        sy_f <= sy_s[2];
      sy_q <= sy_f;
    end
  end

  // Scan timebase: free running, or restarted by each incoming sync rising edge
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      scan_cnt <= '0;
      scan_tick <= 1'b0;
    end
    else if (sync_sel == SYNC_SLAVE)
    begin
      scan_tick <= sy_f && !sy_q;
      if (sy_f && !sy_q)
        scan_cnt <= '0;
      else if (scan_cnt != SCW'(SCAN_COUNT - 1))
        scan_cnt <= scan_cnt + 1'b1;
    end
    else
    begin
      scan_tick <= (scan_cnt == SCW'(SCAN_COUNT - 1));
      if (scan_cnt == SCW'(SCAN_COUNT - 1))
        scan_cnt <= '0;
      else
        scan_cnt <= scan_cnt + 1'b1;
    end
  end

  // Sync pin: driven only as master, high for the first half of each scan
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sync_oe <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      sync_oe <= (sync_sel == SYNC_MASTER);
      sync_o <= (sync_sel == SYNC_MASTER) && (scan_cnt < SCW'(SCAN_COUNT / 2));
    end
  end

  // De-ghost resistors follow each line's off state; no loss through them while on
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cs_pulldown_en <= '0;
      sw_pullup_en <= '0;
      sw_pullup_sel <= RST_SWITCH_PULLUP_SELECT;
      cs_pulldown_sel <= RST_SOURCE_PULLDOWN_SELECT;
    end
    else
    begin
      cs_pulldown_en <= ~cs_on;
      sw_pullup_en <= ~sw_on;
      sw_pullup_sel <= switch_pullup_select;
      cs_pulldown_sel <= source_pulldown_select;
    end
  end
endmodule

// ===== shared/led_ctrl_pkg.sv
// Constants shared by the LED matrix control logic
package led_ctrl_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CHIP_CONFIGURATION     = 8'h00;
  localparam logic [7:0] OFS_SWITCH_PULLUP_SELECT   = 8'h0f;
  localparam logic [7:0] OFS_SOURCE_PULLDOWN_SELECT = 8'h10;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE_MASK  = 8'hf0;
  localparam logic [7:0] OFS_INTERRUPT_FLAGS        = 8'hf1;
  // Reset values
  localparam logic [7:0] RST_CHIP_CONFIGURATION     = 8'h00;
  localparam logic [7:0] RST_SWITCH_PULLUP_SELECT   = 8'h00;
  localparam logic [7:0] RST_SOURCE_PULLDOWN_SELECT = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_ENABLE_MASK  = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_FLAGS        = 8'h00;
  // Configuration fields
  localparam int CFG_SOFT_SHUTDOWN_N = 0;
  localparam int CFG_BREATH_EN       = 1;
  localparam int CFG_DETECT_TRIGGER  = 2;
  localparam int CFG_SYNC_LO         = 6;
  // Event bits, shared by mask and flags; the auto-clear bit is in the mask only
  localparam int EV_OPEN   = 0;
  localparam int EV_SHORT  = 1;
  localparam int EV_ABM_LO = 2;
  localparam int EV_COUNT  = 5;
  localparam int MASK_IRQ_AUTO_CLEAR = 5;
  // Sync select encodings
  typedef enum logic [1:0] {
    SYNC_OFF    = 2'b00,
    SYNC_MASTER = 2'b01,
    SYNC_SLAVE  = 2'b10,
    SYNC_OFF2   = 2'b11
  } sync_sel_t;
  // Timing
  localparam longint CLK_HZ            = 125_000_000;
  localparam longint AUTO_CLEAR_MS     = 8;
  localparam longint AUTO_CLEAR_CYCLES = AUTO_CLEAR_MS * CLK_HZ / 1000;
  localparam longint SCAN_NS           = 136_000;
  localparam longint SCAN_CYCLES       = SCAN_NS * CLK_HZ / 1_000_000_000;
  // Link address, arbitrary neutral value
  localparam logic [6:0] DEV_ADDR = 7'h50;
endpackage

// ===== shared/host_reg_if.sv
// Register access carrier between the serial link and the register file
interface host_reg_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport link (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// ===== core/serial_slave.sv
// Two-wire serial slave: pointer write, burst write and burst read
module serial_slave
  import led_ctrl_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  host_reg_if.link  bus
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b011,
    ST_WBYTE = 3'b010,
    ST_WACK  = 3'b110,
    ST_RBYTE = 3'b111,
    ST_RACK  = 3'b101
  } st_t;

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic       scl_f;
  logic       sda_f;
  logic       scl_q;
  logic       sda_q;
  st_t        st;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic       rw;
  logic       first;
  logic       nack;
  logic [7:0] ptr;

  // Pins pass three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    scl_s <= {scl_s[1:0], scl_i};
    sda_s <= {sda_s[1:0], sda_i};
    if (srst)
    begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      if (scl_s[2] == scl_s[1])
        scl_f <= scl_s[2];
      if (sda_s[2] == sda_s[1])
        sda_f <= sda_s[2];
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire rise  = scl_f & ~scl_q;
  wire fall  = ~scl_f & scl_q;
  wire start = scl_f & scl_q & sda_q & ~sda_f;
  wire stop  = scl_f & scl_q & ~sda_q & sda_f;

  assign bus.addr = ptr;
  assign bus.wdata = shift;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st <= ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      nack <= 1'b0;
      ptr <= 8'h00;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
    end
    else
    begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      // Pointer advances after the strobe cycle so the register file sees a stable address
      if (bus.wr_stb | bus.rd_stb)
        ptr <= ptr + 8'h01;
      if (start)
      begin
        st <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop)
      begin
        st <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else if (rise)
      begin
        shift <= {shift[6:0], sda_f};
        cnt <= cnt + 4'h1;
        if (st == ST_RACK)
          nack <= sda_f;
      end
      else if (fall)
      begin
        case (st)
          ST_ADDR:
            if (cnt == 4'h8)
            begin
              if (shift[7:1] == DEV_ADDR)
              begin
                sda_oe <= 1'b1;
                rw <= shift[0];
                st <= ST_AACK;
              end
              else
                st <= ST_IDLE;
            end
          ST_AACK:
          begin
            cnt <= 4'h0;
            first <= 1'b1;
            if (rw)
            begin
              tx <= bus.rdata;
              sda_oe <= ~bus.rdata[7];
              st <= ST_RBYTE;
            end
            else
            begin
              sda_oe <= 1'b0;
              st <= ST_WBYTE;
            end
          end
          ST_WBYTE:
            if (cnt == 4'h8)
            begin
              sda_oe <= 1'b1;
              st <= ST_WACK;
              first <= 1'b0;
              if (first)
                ptr <= shift;
              else
                bus.wr_stb <= 1'b1;
            end
          ST_WACK:
          begin
            sda_oe <= 1'b0;
            cnt <= 4'h0;
            st <= ST_WBYTE;
          end
          ST_RBYTE:
            if (cnt == 4'h8)
            begin
              // Byte fully shifted out: this is a completed read
              sda_oe <= 1'b0;
              bus.rd_stb <= 1'b1;
              st <= ST_RACK;
            end
            else
              sda_oe <= ~tx[3'(4'h7 - cnt)];
          ST_RACK:
            if (nack)
              st <= ST_IDLE;
            else
            begin
              tx <= bus.rdata;
              sda_oe <= ~bus.rdata[7];
              cnt <= 4'h0;
              st <= ST_RBYTE;
            end
          default:
            st <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== bench/led_ctrl_monitor.sv
// Port checker for the LED matrix control block, bound into it
module led_ctrl_monitor #(
  parameter int CS_LINES = 4,
  parameter int SW_LINES = 3
)
(
  input wire logic                ref_clk,
  input wire logic                srst,
  input wire logic                hw_shutdown_n,
  input wire logic                open_event,
  input wire logic                short_event,
  input wire logic [2:0]          breath_done,
  input wire logic [CS_LINES-1:0] cs_on,
  input wire logic [SW_LINES-1:0] sw_on,
  input wire logic                irq_out_n,
  input wire logic                sync_o,
  input wire logic                sync_oe,
  input wire logic                scan_tick,
  input wire logic                source_enable,
  input wire logic                analog_enable,
  input wire logic [CS_LINES-1:0] cs_pulldown_en,
  input wire logic [SW_LINES-1:0] sw_pullup_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Checked through reset itself, so the default disable is overridden
  property p_rst_quiet;
    disable iff (1'b0) srst |=> irq_out_n && !sync_oe && !source_enable;
  endproperty
  property p_irq_cause;
    $fell(irq_out_n) |-> $past(open_event || short_event || (|breath_done));
  endproperty
  property p_hw_enter;
    $fell(hw_shutdown_n) |-> ##[2:8] !analog_enable;
  endproperty
  property p_hw_leave;
    $rose(hw_shutdown_n) |-> ##[2:8] analog_enable;
  endproperty
  property p_hw_blank;
    (!hw_shutdown_n)[*8] |-> !source_enable && !analog_enable;
  endproperty
  property p_cs_pull;
    !$past(srst) |-> cs_pulldown_en == ~$past(cs_on);
  endproperty
  property p_sw_pull;
    !$past(srst) |-> sw_pullup_en == ~$past(sw_on);
  endproperty
  // Half of a 20-cycle scan period; the bench runs that period
  property p_master_high;
    sync_oe[*8] ##1 sync_oe[*4] ##0 $fell(sync_o) |-> $past(sync_o, 10) && !$past(sync_o, 11);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not idle after reset");
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt fell without an event");
  a_hw_enter: assert property (p_hw_enter)
    else $error("analog still on in hardware shutdown");
  a_hw_leave: assert property (p_hw_leave)
    else $error("analog not back after shutdown pin high");
  a_hw_blank: assert property (p_hw_blank)
    else $error("sources on during hardware shutdown");
  a_cs_pull: assert property (p_cs_pull)
    else $error("source pull-down not following off state");
  a_sw_pull: assert property (p_sw_pull)
    else $error("switch pull-up not following off state");
  a_master_high: assert property (p_master_high)
    else $error("master sync high phase wrong length");
  c_irq_low: cover property ($fell(irq_out_n));
  c_irq_high: cover property ($rose(irq_out_n));
  c_master: cover property (sync_oe && $fell(sync_o));
  c_slave_tick: cover property (scan_tick && !sync_oe);
endmodule

bind led_ctrl led_ctrl_monitor #(.CS_LINES(CS_LINES), .SW_LINES(SW_LINES)) led_ctrl_monitor_inst (
  .ref_clk, .srst, .hw_shutdown_n, .open_event, .short_event, .breath_done, .cs_on, .sw_on,
  .irq_out_n, .sync_o, .sync_oe, .scan_tick, .source_enable, .analog_enable, .cs_pulldown_en,
  .sw_pullup_en
);

// ===== bench/host_master.sv
// Host microcontroller model: two-wire master on the serial pins
module host_master
  import led_ctrl_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // Eight clocks a phase leaves margin over the pin synchronisers
  localparam int PHASE = 8;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic put_bit(input logic b, output logic seen);
    tick(2);
    sda_pull = !b;
    tick(PHASE);
    scl = 1'b1;
    tick(PHASE);
    seen = sda_line;
    scl = 1'b0;
  endtask
  task automatic start_cond();
    tick(2);
    sda_pull = 1'b0;
    tick(PHASE);
    scl = 1'b1;
    tick(PHASE);
    sda_pull = 1'b1;
    tick(PHASE);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    tick(2);
    sda_pull = 1'b1;
    tick(PHASE);
    scl = 1'b1;
    tick(PHASE);
    sda_pull = 1'b0;
    tick(PHASE);
  endtask
  // Released ninth bit: acknowledge seen from the device, or our own NACK
  task automatic put_byte(input logic [7:0] v, output logic [7:0] got, output logic nak);
    for (int i = 7; i >= 0; i--)
      put_bit(v[i], got[i]);
    put_bit(1'b1, nak);
  endtask
  task automatic reg_write(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic nak);
    logic [7:0] g;
    logic [2:0] n;
    start_cond();
    put_byte({dev, 1'b0}, g, n[0]);
    put_byte(a, g, n[1]);
    put_byte(d, g, n[2]);
    stop_cond();
    nak = |n;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] g;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, g, g[0]);
    put_byte(a, g, g[0]);
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, g, g[0]);
    put_byte(8'hff, d, g[0]);
    stop_cond();
  endtask
endmodule

// ===== bench/tb_led_ctrl.sv
// Self-checking bench for the LED matrix control block
module tb_led_ctrl
  import led_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AC_N = 50;
  localparam int SC_N = 20;
  logic       ref_clk;
  logic       srst;
  logic       scl;
  logic       host_pull;
  logic       sda_oe;
  logic       sda_line;
  logic       hw_shutdown_n;
  logic       sync_drv;
  logic       sync_line;
  logic       sync_o;
  logic       sync_oe;
  logic       open_event;
  logic       short_event;
  logic [2:0] breath_done;
  logic [3:0] cs_on;
  logic [2:0] sw_on;
  logic       irq_out_n;
  logic       scan_tick;
  logic       source_enable;
  logic       analog_enable;
  logic [3:0] cs_pd;
  logic [2:0] sw_pu;
  logic [7:0] pu_sel;
  logic [7:0] pd_sel;
  logic       brth;
  logic       det;
  int         det_n = 0;
  int         failures;
  int         checked;
  assign sda_line = !(sda_oe || host_pull);
  assign sync_line = sync_oe ? sync_o : sync_drv;
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  led_ctrl #(.AUTO_CLEAR_COUNT(AC_N), .SCAN_COUNT(SC_N)) led_ctrl_inst (
    .ref_clk, .srst, .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe, .hw_shutdown_n,
    .sync_i(sync_line), .sync_o, .sync_oe, .open_event, .short_event, .breath_done, .cs_on,
    .sw_on, .irq_out_n, .scan_tick, .source_enable, .analog_enable, .breath_enable(brth),
    .detect_start(det), .cs_pulldown_en(cs_pd), .sw_pullup_en(sw_pu), .sw_pullup_sel(pu_sel),
    .cs_pulldown_sel(pd_sel)
  );
  host_master host_master_inst (.ref_clk, .sda_line, .scl, .sda_pull(host_pull));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bchk(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic nak;
    host_master_inst.reg_write(DEV_ADDR, a, d, nak);
    bchk("write nak", 1'b0, nak);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_master_inst.reg_read(a, v);
    chk(what, exp, v);
  endtask
  task automatic pulse(input int idx);
    @(negedge ref_clk);
    {breath_done, short_event, open_event} = 5'h01 << idx;
    @(negedge ref_clk);
    {breath_done, short_event, open_event} = 5'h00;
    @(negedge ref_clk);
  endtask
  task automatic t_reset();
    logic nak;
    bchk("irq idle", 1'b1, irq_out_n);
    bchk("sync idle", 1'b0, sync_oe);
    rd_chk("config", OFS_CHIP_CONFIGURATION, RST_CHIP_CONFIGURATION);
    rd_chk("pullup", OFS_SWITCH_PULLUP_SELECT, RST_SWITCH_PULLUP_SELECT);
    rd_chk("pulldown", OFS_SOURCE_PULLDOWN_SELECT, RST_SOURCE_PULLDOWN_SELECT);
    rd_chk("mask", OFS_INTERRUPT_ENABLE_MASK, RST_INTERRUPT_ENABLE_MASK);
    rd_chk("flags", OFS_INTERRUPT_FLAGS, RST_INTERRUPT_FLAGS);
    rd_chk("unmapped", 8'h05, 8'h00);
    host_master_inst.reg_write(DEV_ADDR + 7'h01, 8'h00, 8'h01, nak);
    bchk("foreign nak", 1'b1, nak);
    $display("test reset done");
  endtask
  // Every event source in turn, with a masked neighbour that must stay silent
  task automatic t_irq();
    for (int i = 0; i < EV_COUNT; i++)
    begin
      wr(OFS_INTERRUPT_ENABLE_MASK, 8'h01 << i);
      pulse((i + 1) % EV_COUNT);
      bchk("irq masked", 1'b1, irq_out_n);
      pulse(i);
      bchk("irq raised", 1'b0, irq_out_n);
      rd_chk("flag set", OFS_INTERRUPT_FLAGS, 8'h01 << i);
      bchk("irq released", 1'b1, irq_out_n);
      rd_chk("flags zero", OFS_INTERRUPT_FLAGS, 8'h00);
    end
    $display("test irq done");
  endtask
  task automatic t_auto();
    int n;
    wr(OFS_INTERRUPT_ENABLE_MASK, 8'h21);
    pulse(EV_OPEN);
    n = 2;
    while (irq_out_n === 1'b0 && n < 4 * AC_N)
    begin
      @(negedge ref_clk);
      n++;
    end
    bchk("auto span", 1'b1, n >= AC_N && n <= AC_N + 3);
    rd_chk("auto flags", OFS_INTERRUPT_FLAGS, 8'h00);
    $display("test auto clear done");
  endtask
  task automatic t_sync();
    int n;
    wr(OFS_CHIP_CONFIGURATION, 8'h41);
    bchk("master oe", 1'b1, sync_oe);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      while (sync_o !== k[0] && n < 4 * SC_N)
      begin
        @(negedge ref_clk);
        n++;
      end
    end
    chk("master high", 8'(SC_N / 2), 8'(n));
    wr(OFS_CHIP_CONFIGURATION, 8'h81);
    bchk("slave oe", 1'b0, sync_oe);
    sync_drv = 1'b1;
    n = 0;
    while (scan_tick !== 1'b1 && n < 4 * SC_N)
    begin
      @(negedge ref_clk);
      n++;
    end
    bchk("slave lock", 1'b1, n >= 3 && n <= 7);
    sync_drv = 1'b0;
    wr(OFS_CHIP_CONFIGURATION, 8'hc1);
    bchk("off3 oe", 1'b0, sync_oe);
    wr(OFS_CHIP_CONFIGURATION, 8'h41);
    wr(OFS_CHIP_CONFIGURATION, 8'h01);
    bchk("off0 oe", 1'b0, sync_oe);
    $display("test sync done");
  endtask
  task automatic t_shut();
    bchk("sources on", 1'b1, source_enable);
    wr(OFS_CHIP_CONFIGURATION, 8'h00);
    bchk("sources off", 1'b0, source_enable);
    wr(OFS_SWITCH_PULLUP_SELECT, 8'h5a);
    rd_chk("pullup soft", OFS_SWITCH_PULLUP_SELECT, 8'h5a);
    chk("pullup sel", 8'h5a, pu_sel);
    hw_shutdown_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    bchk("analog off", 1'b0, analog_enable);
    wr(OFS_SOURCE_PULLDOWN_SELECT, 8'ha5);
    rd_chk("pulldown hw", OFS_SOURCE_PULLDOWN_SELECT, 8'ha5);
    rd_chk("pullup kept", OFS_SWITCH_PULLUP_SELECT, 8'h5a);
    chk("pulldown sel", 8'ha5, pd_sel);
    wr(OFS_CHIP_CONFIGURATION, 8'h01);
    bchk("hw blank", 1'b0, source_enable);
    cs_on = 4'h5;
    sw_on = 3'h6;
    repeat (2) @(negedge ref_clk);
    chk("pulldown en", 8'h0a, {4'h0, cs_pd});
    chk("pullup en", 8'h01, {5'h00, sw_pu});
    wr(OFS_SWITCH_PULLUP_SELECT, 8'h5a);
    hw_shutdown_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    bchk("analog on", 1'b1, analog_enable);
    bchk("sources back", 1'b1, source_enable);
    rd_chk("config kept", OFS_CHIP_CONFIGURATION, 8'h01);
    $display("test shutdown done");
  endtask
  // Detection start is a one-cycle pulse, so it is counted rather than sampled
  always @(negedge ref_clk)
    if (det === 1'b1)
      det_n++;
  task automatic t_detect();
    wr(OFS_CHIP_CONFIGURATION, 8'h07);
    chk("detect pulses", 8'h01, 8'(det_n));
    bchk("breath on", 1'b1, brth);
    wr(OFS_CHIP_CONFIGURATION, 8'h07);
    chk("detect held", 8'h01, 8'(det_n));
    wr(OFS_CHIP_CONFIGURATION, 8'h01);
    wr(OFS_CHIP_CONFIGURATION, 8'h05);
    chk("detect again", 8'h02, 8'(det_n));
    bchk("breath off", 1'b0, brth);
    $display("test detect done");
  endtask
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    srst = 1'b1;
    hw_shutdown_n = 1'b1;
    sync_drv = 1'b0;
    {breath_done, short_event, open_event} = 5'h00;
    cs_on = 4'h0;
    sw_on = 3'h0;
    failures = 0;
    checked = 0;
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    repeat (8) @(negedge ref_clk);
    t_reset();
    t_irq();
    t_auto();
    t_sync();
    t_detect();
    t_shut();
    close_out();
  end
  // Tests need about 27000 cycles; this leaves more than double
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    $display("Error watchdog expected done seen timeout");
    close_out();
  end
endmodule
